//--- core/imia_regs.sv
// Interrupt enable registers and indirect access window
// How it works
// - Enable bit 1 passes source, 0 masks
// - First enable: six timer/tone enables D5..D0
// - Spare bits of first enable D7..D6 and third enable D0 store value, no function
// - Second enable D7..D2: power alarm enables
// - Second enable D1: hook change enable
// - Second enable D0: ring trip enable
// - Third enable D1 done enable, 7:2 zero
// - Sixteen-bit window, two bytes, reset zero
// - Address register resets to zero until host writes
// - Data then address writes location next tick
// - Address alone reads location next tick
// - Transfers happen on 16 kHz update ticks
// - Done pending flag set after transfer
// - Status bit D0 shows access pending
// - Writing 1 clears pending flags
//
// Chosen here: strobed register access.
module imia_regs
    import imia_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    nrst_i,
    // Register port
    input  wire imia_pkg::imia_bus_req_t bus_i,
    output logic [7:0]                   rdata_o,
    // Interrupt sources, one-cycle event pulses
    input  wire imia_pkg::imia_events_t  events_i,
    // Interrupt output
    output logic                         irq_o
);
    import imia_pkg::*;

    logic [7:0]  timer_en_q;
    logic [7:0]  line_en_q;
    logic [7:0]  done_en_q;
    logic [7:0]  win_lo_q;
    logic [7:0]  win_hi_q;
    logic [7:0]  win_addr_q;
    logic [5:0]  stat1_q;
    logic [7:0]  stat2_q;
    logic        done_pend_q;
    logic        data_wr_q;
    logic        acc_pend_q;
    imia_state_t state_q;
    imia_state_t state_d;
    logic [15:0] tick_cnt_q;
    logic [7:0]  rdata_q;
    logic        irq_q;
    logic [15:0] mem_q [MEM_DEPTH];

    // Decode
    wire wr_tim   = bus_i.wr && bus_i.addr == OFS_TIMER_EN;
    wire wr_line  = bus_i.wr && bus_i.addr == OFS_LINE_EN;
    wire wr_done  = bus_i.wr && bus_i.addr == OFS_DONE_EN;
    wire wr_lo    = bus_i.wr && bus_i.addr == OFS_WIN_LO;
    wire wr_hi    = bus_i.wr && bus_i.addr == OFS_WIN_HI;
    wire wr_addr  = bus_i.wr && bus_i.addr == OFS_WIN_ADDR;
    wire wr_st1   = bus_i.wr && bus_i.addr == OFS_STAT1;
    wire wr_st2   = bus_i.wr && bus_i.addr == OFS_STAT2;
    wire wr_st3   = bus_i.wr && bus_i.addr == OFS_STAT3;
    wire tick     = tick_cnt_q == 16'(TICK_CYCLES - 1);
    wire xfer_end = tick && state_q != ST_IDLE;
    wire [5:0] clr1 = wr_st1 ? bus_i.wdata[5:0] : 6'h00;
    wire [7:0] clr2 = wr_st2 ? bus_i.wdata : 8'h00;
    wire       clr3 = wr_st3 && bus_i.wdata[DONE_PEND_BIT];

    // Masked sources
    wire [5:0] act1 = stat1_q & timer_en_q[5:0];
    wire [7:0] act2 = stat2_q & line_en_q;
    wire       act3 = done_pend_q & done_en_q[DONE_EN_BIT];
    wire       irq_d = |act1 || |act2 || act3;

    wire [7:0] rd_mux =
        bus_i.addr == OFS_TIMER_EN ? timer_en_q :
        bus_i.addr == OFS_LINE_EN  ? line_en_q :
        bus_i.addr == OFS_DONE_EN  ? (done_en_q & DONE_EN_MASK) :
        bus_i.addr == OFS_WIN_LO   ? win_lo_q :
        bus_i.addr == OFS_WIN_HI   ? win_hi_q :
        bus_i.addr == OFS_WIN_ADDR ? win_addr_q :
        bus_i.addr == OFS_STAT1    ? {2'b00, stat1_q} :
        bus_i.addr == OFS_STAT2    ? stat2_q :
        bus_i.addr == OFS_STAT3    ? {6'h00, done_pend_q, 1'b0} :
        bus_i.addr == OFS_ACC_STAT ? {7'h00, acc_pend_q} :
        8'h00;

    // Request sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (wr_addr)
                    state_d = data_wr_q ? ST_WRITE : ST_READ;
            end
            ST_WRITE, ST_READ:
            begin
                if (tick)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tick_cnt_q <= 16'h0000;
        else if (tick)
            tick_cnt_q <= 16'h0000;
        else
            tick_cnt_q <= tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            timer_en_q <= EN_RST;
            line_en_q  <= EN_RST;
            done_en_q  <= EN_RST;
        end
        else
        begin
            if (wr_tim)
                timer_en_q <= bus_i.wdata;
            if (wr_line)
                line_en_q <= bus_i.wdata;
            if (wr_done)
                done_en_q <= bus_i.wdata & DONE_EN_MASK;
        end
    end

    // Window and address
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            win_lo_q   <= WIN_RST;
            win_hi_q   <= WIN_RST;
            win_addr_q <= ADDR_RST;
            data_wr_q  <= 1'b0;
        end
        else
        begin
            if (xfer_end && state_q == ST_READ)
            begin
                win_lo_q <= mem_q[win_addr_q][7:0];
                win_hi_q <= mem_q[win_addr_q][15:8];
            end
            else
            begin
                if (wr_lo)
                    win_lo_q <= bus_i.wdata;
                if (wr_hi)
                    win_hi_q <= bus_i.wdata;
            end
            if (wr_addr && state_q == ST_IDLE)
                win_addr_q <= bus_i.wdata;
            if (wr_lo || wr_hi)
                data_wr_q <= 1'b1;
            else if (wr_addr && state_q == ST_IDLE)
                data_wr_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (xfer_end && state_q == ST_WRITE)
            mem_q[win_addr_q] <= {win_hi_q, win_lo_q};
    end

    // Status flags, set beats clear
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q     <= ST_IDLE;
            acc_pend_q  <= 1'b0;
            stat1_q     <= 6'h00;
            stat2_q     <= 8'h00;
            done_pend_q <= 1'b0;
            rdata_q     <= 8'h00;
            irq_q       <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            acc_pend_q  <= state_d != ST_IDLE;
            stat1_q     <= (stat1_q & ~clr1) | events_i.timer;
            stat2_q     <= (stat2_q & ~clr2) | events_i.line;
            done_pend_q <= (done_pend_q && !clr3) || xfer_end;
            rdata_q     <= bus_i.rd ? rd_mux : 8'h00;
            irq_q       <= irq_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o   = irq_q;

    chk_irq_follows_mask: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        irq_d |=> irq_o)
        else $error("irq not raised for enabled pending flag");
    chk_irq_masked_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !irq_d |=> !irq_o)
        else $error("irq raised with all sources masked");
    chk_done_after_xfer: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        xfer_end |=> done_pend_q && !acc_pend_q)
        else $error("done flag not set after transfer");
    chk_pend_on_addr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_addr && state_q == ST_IDLE) |=> acc_pend_q)
        else $error("pending not shown after address write");
    chk_xfer_on_tick: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (acc_pend_q && $past(acc_pend_q) && !$past(tick)) |-> $stable(win_addr_q))
        else $error("address moved while transfer pending");
    chk_read_loads_win: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (xfer_end && state_q == ST_READ) |=> win_lo_q == mem_q[win_addr_q][7:0])
        else $error("window not loaded by read");
    chk_write_stores: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (xfer_end && state_q == ST_WRITE) |=> mem_q[win_addr_q] == {win_hi_q, win_lo_q})
        else $error("location not written");
    chk_clear_w1c: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (clr3 && !xfer_end) |=> !done_pend_q)
        else $error("done flag not cleared by write of one");
    chk_done_en_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        done_en_q[7:2] == 6'h00)
        else $error("reserved enable bits not zero");

    // Enable and window storage
    chk_timer_en_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_tim |=> timer_en_q == $past(bus_i.wdata))
        else $error("first enable register not stored");
    chk_line_en_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_line |=> line_en_q == $past(bus_i.wdata))
        else $error("second enable register not stored");
    chk_done_en_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_done |=> done_en_q[1:0] == $past(bus_i.wdata[1:0]))
        else $error("third enable register not stored");
    chk_win_lo_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_lo && !(xfer_end && state_q == ST_READ)) |=> win_lo_q == $past(bus_i.wdata))
        else $error("window low byte not stored");
    chk_win_hi_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_hi && !(xfer_end && state_q == ST_READ)) |=> win_hi_q == $past(bus_i.wdata))
        else $error("window high byte not stored");
    chk_addr_store: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_addr && state_q == ST_IDLE) |=> win_addr_q == $past(bus_i.wdata))
        else $error("address not stored");
    chk_addr_busy_kept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_addr && state_q != ST_IDLE) |=> $stable(win_addr_q))
        else $error("address changed during transfer");

    // Transfer sequencing
    chk_data_then_addr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_addr && state_q == ST_IDLE && data_wr_q) |=> state_q == ST_WRITE)
        else $error("write transfer not started");
    chk_addr_only_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_addr && state_q == ST_IDLE && !data_wr_q) |=> state_q == ST_READ)
        else $error("read transfer not started");
    chk_pend_until_tick: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (state_q != ST_IDLE && !tick) |=> acc_pend_q)
        else $error("transfer ended before tick");
    chk_tick_wraps: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        tick |=> tick_cnt_q == 16'h0000)
        else $error("tick counter did not wrap");

    // Flag behaviour
    chk_stat1_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_st1 && events_i.timer == 6'h00) |=> (stat1_q & $past(bus_i.wdata[5:0])) == 6'h00)
        else $error("timer flags not cleared by one");
    chk_stat2_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (wr_st2 && events_i.line == 8'h00) |=> (stat2_q & $past(bus_i.wdata)) == 8'h00)
        else $error("line flags not cleared by one");
    chk_stat1_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_st1 |=> (($past(stat1_q) & ~$past(bus_i.wdata[5:0])) & ~stat1_q) == 6'h00)
        else $error("timer flag lost on write of zero");
    chk_stat2_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_st2 |=> (($past(stat2_q) & ~$past(bus_i.wdata)) & ~stat2_q) == 8'h00)
        else $error("line flag lost on write of zero");
    chk_stat1_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (events_i.timer != 6'h00) |=> (stat1_q & $past(events_i.timer)) == $past(events_i.timer))
        else $error("timer event not latched");
    chk_stat2_set: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (events_i.line != 8'h00) |=> (stat2_q & $past(events_i.line)) == $past(events_i.line))
        else $error("line event not latched");
    chk_all_masked: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (act1 == 6'h00 && act2 == 8'h00 && !done_en_q[DONE_EN_BIT]) |=> !irq_o)
        else $error("irq raised with all enables low");

    // Read port
    chk_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero without strobe");
    chk_acc_stat_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (bus_i.rd && bus_i.addr == OFS_ACC_STAT) |=> rdata_o == {7'h00, $past(acc_pend_q)})
        else $error("access status read wrong");
    chk_stat3_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (bus_i.rd && bus_i.addr == OFS_STAT3) |=> rdata_o[7:2] == 6'h00 && !rdata_o[0])
        else $error("third status spare bits not zero");
    chk_done_en_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (bus_i.rd && bus_i.addr == OFS_DONE_EN) |=> rdata_o[7:2] == 6'h00)
        else $error("third enable spare bits read nonzero");
endmodule

//--- shared/imia_pkg.sv
// Package for the interrupt enable and indirect access register block
package imia_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          WIN_W          = 16;
    localparam int          MEM_DEPTH      = 256;
    // Register offsets
    localparam logic [7:0]  OFS_STAT1      = 8'h12;
    localparam logic [7:0]  OFS_STAT2      = 8'h13;
    localparam logic [7:0]  OFS_STAT3      = 8'h14;
    localparam logic [7:0]  OFS_TIMER_EN   = 8'h15;
    localparam logic [7:0]  OFS_LINE_EN    = 8'h16;
    localparam logic [7:0]  OFS_DONE_EN    = 8'h17;
    localparam logic [7:0]  OFS_WIN_LO     = 8'h1C;
    localparam logic [7:0]  OFS_WIN_HI     = 8'h1D;
    localparam logic [7:0]  OFS_WIN_ADDR   = 8'h1E;
    localparam logic [7:0]  OFS_ACC_STAT   = 8'h1F;
    // Field positions
    localparam int          DONE_EN_BIT    = 1;
    localparam int          DONE_PEND_BIT  = 1;
    localparam int          ACC_PEND_BIT   = 0;
    localparam logic [7:0]  STAT1_MASK     = 8'h3F;
    localparam logic [7:0]  DONE_EN_MASK   = 8'h03;
    // Reset values
    localparam logic [7:0]  EN_RST         = 8'h00;
    localparam logic [7:0]  WIN_RST        = 8'h00;
    localparam logic [7:0]  ADDR_RST       = 8'h00;
    // Update tick timing
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          TICK_HZ        = 16_000;
    localparam int          TICK_CYC       = CLK_HZ / TICK_HZ;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } imia_bus_req_t;

    typedef struct packed {
        logic [5:0] timer;
        logic [7:0] line;
        logic       done_unused;
    } imia_events_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } imia_state_t;
endpackage

//--- testbench/imia_host.sv
// Host controller model for the register port
module imia_host
    import imia_pkg::*;
(
    // Clock
    input  wire logic                    ref_clk_i,
    // Register port
    output imia_pkg::imia_bus_req_t      bus_o,
    input  wire logic [7:0]              rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus_o = '0;
    // Takes the bus back to idle
    task automatic idle();
        bus_o <= '0;
    endtask
    // Write strobe; stays up until the next call or idle lowers it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
    endtask
    // One-cycle read strobe, data taken at the end of the next cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        bus_o <= '0;
        @(posedge ref_clk_i);
        d = rdata_i;
    endtask
    // Polls access status until idle
    task automatic wait_idle(output int n);
        logic [7:0] s;
        n = 0;
        s = 8'h01;
        while (s[ACC_PEND_BIT] !== 1'b0 && n < 40)
        begin
            rd(OFS_ACC_STAT, s);
            n++;
        end
    endtask
endmodule

//--- testbench/irq_mask_indirect_access_tb_top.sv
// Self-checking testbench for the enable and indirect access registers
module irq_mask_indirect_access_tb_top;
    import imia_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TCYC = 8;
    logic          ref_clk_i;
    logic          nrst_i;
    imia_bus_req_t bus;
    logic [7:0]    rdata;
    imia_events_t  ev;
    logic          irq;
    int            failures;
    int            cmp_count;

    imia_regs #(.TICK_CYCLES(TCYC)) i_imia_regs (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .bus_i(bus), .rdata_o(rdata), .events_i(ev), .irq_o(irq));
    imia_host i_imia_host (.ref_clk_i(ref_clk_i), .bus_o(bus), .rdata_i(rdata));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_imia_host.rd(a, d);
        cmp8(d, exp);
    endtask
    task automatic irqchk(input logic exp);
        i_imia_host.idle();
        repeat (2) @(posedge ref_clk_i);
        cmp8({7'h00, irq}, {7'h00, exp});
    endtask
    task automatic conclude();
        $display("Counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic t_reset();
        rchk(OFS_TIMER_EN, 8'h00);
        rchk(OFS_LINE_EN, 8'h00);
        rchk(OFS_DONE_EN, 8'h00);
        rchk(OFS_WIN_LO, 8'h00);
        rchk(OFS_WIN_HI, 8'h00);
        rchk(8'h00, 8'h00);
        cmp8({7'h00, irq}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_enables();
        i_imia_host.wr(OFS_TIMER_EN, 8'hFF);
        rchk(OFS_TIMER_EN, 8'hFF);
        i_imia_host.wr(OFS_LINE_EN, 8'hA5);
        rchk(OFS_LINE_EN, 8'hA5);
        i_imia_host.wr(OFS_DONE_EN, 8'hFF);
        rchk(OFS_DONE_EN, 8'h03);
        i_imia_host.wr(OFS_TIMER_EN, 8'h00);
        i_imia_host.wr(OFS_LINE_EN, 8'h00);
        i_imia_host.wr(OFS_DONE_EN, 8'h00);
        i_imia_host.idle();
        $display("test enables done");
    endtask
    task automatic t_mask();
        logic [7:0] en;
        logic [7:0] st;
        logic [7:0] m;
        for (int i = 0; i < 14; i++)
        begin
            en = (i < 6) ? OFS_TIMER_EN : OFS_LINE_EN;
            st = (i < 6) ? OFS_STAT1 : OFS_STAT2;
            m = (i < 6) ? 8'(1 << i) : 8'(1 << (i - 6));
            @(posedge ref_clk_i);
            ev <= (i < 6) ? imia_events_t'(1 << (9 + i)) : imia_events_t'(1 << (i - 5));
            @(posedge ref_clk_i);
            ev <= '0;
            irqchk(1'b0);
            rchk(st, m);
            i_imia_host.wr(en, m);
            irqchk(1'b1);
            i_imia_host.wr(st, 8'h00);
            irqchk(1'b1);
            i_imia_host.wr(st, m);
            irqchk(1'b0);
            i_imia_host.wr(en, 8'h00);
            i_imia_host.idle();
        end
        $display("test mask done");
    endtask
    task automatic access(input logic [7:0] a);
        int n;
        i_imia_host.wr(OFS_WIN_ADDR, a);
        rchk(OFS_ACC_STAT, 8'h01);
        i_imia_host.wait_idle(n);
        cmp8({7'h00, n <= TCYC + 2}, 8'h01);
        if (n >= 40)
            conclude();
        rchk(OFS_STAT3, 8'h02);
        cmp8({7'h00, irq}, 8'h01);
        i_imia_host.wr(OFS_STAT3, 8'h02);
        irqchk(1'b0);
    endtask
    task automatic t_indirect();
        i_imia_host.wr(OFS_DONE_EN, 8'h02);
        i_imia_host.wr(OFS_WIN_LO, 8'h34);
        i_imia_host.wr(OFS_WIN_HI, 8'h12);
        access(8'h05);
        i_imia_host.wr(OFS_WIN_LO, 8'hCD);
        i_imia_host.wr(OFS_WIN_HI, 8'hAB);
        access(8'h06);
        access(8'h05);
        rchk(OFS_WIN_LO, 8'h34);
        rchk(OFS_WIN_HI, 8'h12);
        access(8'h06);
        rchk(OFS_WIN_LO, 8'hCD);
        rchk(OFS_WIN_HI, 8'hAB);
        $display("test indirect done");
    endtask

    initial
    begin
        nrst_i = 1'b0;
        ev = '0;
        failures = 0;
        cmp_count = 0;
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        t_reset();
        t_enables();
        t_mask();
        t_indirect();
        conclude();
    end
endmodule
